// ===== adcoc_buf2.sv
// Two-entry buffer with valid and ready on both sides
module adcoc_buf2 #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} adcoc_buf_type;

	adcoc_buf_type s;
	adcoc_buf_type next_s;
	logic push;
	logic pop;

	assign in_ready_o = (s.cnt != 2'h2);
	assign out_valid_o = (s.cnt != 2'h0);
	assign out_data_o = s.mem[s.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointer and count update
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_data_i;
			next_s.wp = ~s.wp;
		end
		if (pop) begin
			next_s.rp = ~s.rp;
		end
		next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
		if (!rst_b_i) begin
			next_s.wp = 1'b0;
			next_s.rp = 1'b0;
			next_s.cnt = 2'h0;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i) begin
		s <= next_s;
	end
endmodule : adcoc_buf2

// ===== adcoc_cap_model.sv
// Capture register model that latches words behind the data clock
module adcoc_cap_model (
	// Clock and stall request
	input wire logic ref_clk_i,
	input wire logic stall_i,
	// Converter output bus
	input wire logic [19:0] data_i,
	input wire logic [1:0] ovr_i,
	input wire logic dco_i,
	input wire logic dco_oe_i,
	// Receiver side
	output logic ready_o,
	output logic [21:0] cap_o,
	output logic cap_vld_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Slow receiver: ready drops on request
	assign ready_o = !stall_i;
	// Word already stands once the clock is high; taken only while channel 0's data clock is driven
	always @(posedge ref_clk_i) begin
		cap_vld_o <= dco_i && dco_oe_i;
		cap_o <= {ovr_i, data_i};
	end
endmodule : adcoc_cap_model

// ===== adcoc_pkg.sv
// Shared constants, register map and enumerations of the converter output control
package adcoc_pkg;
	// ********************************
	// Data path shape
	// ********************************
	localparam int SMP_W = 10;
	localparam int CHANS = 2;
	localparam int LATENCY = 9;

	// ********************************
	// Serial port framing
	// ********************************
	localparam int ADDR_W = 13;
	localparam logic [4:0] INSTR_LAST = 5'h0F;
	localparam logic [4:0] FRAME_LAST = 5'h17;
	localparam int RW_BIT = 15;

	// ********************************
	// Register offsets
	// ********************************
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 13'h0001;
	localparam logic [ADDR_W-1:0] ADDR_CHAN = 13'h0005;
	localparam logic [ADDR_W-1:0] ADDR_POWER = 13'h0008;
	localparam logic [ADDR_W-1:0] ADDR_CLOCK = 13'h0009;
	localparam logic [ADDR_W-1:0] ADDR_OUTMODE = 13'h0014;
	localparam logic [ADDR_W-1:0] ADDR_DCO = 13'h0016;

	// ********************************
	// Field positions and reset values
	// ********************************
	localparam int OM_DIS_BIT = 4;
	localparam int DCO_INV_BIT = 7;
	localparam int CLK_DCS_BIT = 0;
	localparam int ST_PD_BIT = 0;
	localparam int ST_SB_BIT = 1;
	localparam int ST_DCS_BIT = 2;
	localparam int ST_SPI_BIT = 3;
	localparam logic [1:0] CHAN_RST = 2'h3;
	localparam logic DCS_RST = 1'b1;

	// ********************************
	// Stabilizer relock wait
	// ********************************
	localparam real CLK_MHZ = 100.0;
	localparam real RELOCK_MAX_US = 5.0;
	localparam int RELOCK_W = 10;
	localparam int RELOCK_CYC_INT = int'(RELOCK_MAX_US * CLK_MHZ);
	localparam logic [RELOCK_W-1:0] RELOCK_CYC = RELOCK_W'(RELOCK_CYC_INT);

	// ********************************
	// Enumerations
	// ********************************
	typedef enum logic [1:0] {FMT_OFFSET, FMT_TWOS, FMT_GRAY} adcoc_fmt_type;
	typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_STANDBY} adcoc_pwr_type;
endpackage : adcoc_pkg

// ===== adcoc_sync.sv
// Two-flop level synchronizer
module adcoc_sync #(
	parameter int W = 1
) (
	// Destination clock
	input wire logic clk_i,
	// Level in and out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} adcoc_sync_type;

	adcoc_sync_type s;
	adcoc_sync_type next_s;

	// First stage feeds only the second
	always_comb begin
		next_s.meta = d_i;
		next_s.stable = s.meta;
	end

	// Data flops, no reset needed
	always_ff @(posedge clk_i) begin
		s <= next_s;
	end

	assign q_o = s.stable;
endmodule : adcoc_sync

// ===== adcoc_top.sv
// Dual-channel converter output control: serial port, power, format and output drive
// Functional notes
// RQ1 - Stabilizer on regenerates falling edge, fifty percent
// RQ2 - Stabilizer unusable below twenty megahertz sample clock
// RQ3 - Host waits relock time after rate change
// RQ4 - Power-down by pin high or serial command
// RQ5 - Powered down: all outputs high impedance
// RQ6 - Pin low returns to normal conversion
// RQ7 - Serial standby keeps reference powered
// RQ8 - Format strap low offset, high twos
// RQ9 - Stabilizer strap low off, high on
// RQ10 - Serial coding: offset, twos or gray
// RQ11 - Output-disable pin high floats data and clocks
// RQ12 - Per-channel output-disable bit four, output_mode_control
// RQ13 - Output word appears nine sample cycles later; code gives ten (eight stages, buffer, output latch)
// RQ14 - Output latch updates after each rising edge; code loads it only on edges that take a word from the buffer
// RQ15 - Data valid at data clock rising edge
// RQ16 - Offset binary coding, twos flips MSB, overrange
// RQ17 - Gray code: bit xor next higher bit
// RQ18 - Power-down when pin or serial setting asks
module adcoc_top #(
	parameter int CH = adcoc_pkg::CHANS,
	parameter int SW = adcoc_pkg::SMP_W,
	parameter int LAT = adcoc_pkg::LATENCY
) (
	// Sample clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Serial port
	input wire logic spi_sclk_i,
	input wire logic spi_cs_b_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_o,
	// Strap and control pins
	input wire logic format_strap_pin_i,
	input wire logic stabilizer_strap_pin_i,
	input wire logic power_down_pin_i,
	input wire logic output_disable_i,
	// Clock monitor from the clock input stage
	input wire logic clock_below_min_i,
	input wire logic clock_rate_change_i,
	// Converter core samples
	input wire logic [CH-1:0][SW-1:0] sample_i,
	input wire logic [CH-1:0] overrange_i,
	// Output bus
	input wire logic out_ready_i,
	output logic [CH-1:0][SW-1:0] data_o,
	output logic [CH-1:0] overrange_o,
	output logic [CH-1:0] data_oe_o,
	output logic [CH-1:0] data_clock_out_o,
	output logic [CH-1:0] data_clock_out_oe_o,
	// Analog control
	output logic duty_stabilizer_o,
	output logic reference_on_o,
	output logic converter_on_o,
	output logic power_down_o
);
	localparam int AW = adcoc_pkg::ADDR_W;
	localparam int NST = LAT - 1;
	localparam int WW = CH * (SW + 1);

	// ********************************
	// Serial clock domain
	// ********************************
	typedef struct packed {
		logic [4:0] cnt;
		logic [14:0] sh;
		logic rd;
		logic [AW-1:0] addr;
		logic [7:0] rdb;
		logic oe;
	} adcoc_frame_type;
	typedef struct packed {
		logic tog;
		logic [AW-1:0] addr;
		logic [7:0] data;
	} adcoc_wr_type;
	adcoc_frame_type f;
	adcoc_frame_type next_f;
	adcoc_wr_type w;
	adcoc_wr_type next_w;
	logic srst_b;
	logic [5:0][7:0] rb_bytes;
	logic [5:0][7:0] rb_sync;
	logic [7:0] rb_sel;

	adcoc_sync #(.W(1)) u_srst (
		.clk_i(spi_sclk_i),
		.d_i(rst_b_i),
		.q_o(srst_b)
	);
	adcoc_sync #(.W(48)) u_rb (
		.clk_i(spi_sclk_i),
		.d_i(rb_bytes),
		.q_o(rb_sync)
	);

	// Readback select on the decoded address; unmapped reads as zero
	always_comb begin
		rb_sel = 8'h00;
		unique case ({f.sh[AW-2:0], sdio_i})
			adcoc_pkg::ADDR_STATUS: rb_sel = rb_sync[0];
			adcoc_pkg::ADDR_CHAN: rb_sel = rb_sync[1];
			adcoc_pkg::ADDR_POWER: rb_sel = rb_sync[2];
			adcoc_pkg::ADDR_CLOCK: rb_sel = rb_sync[3];
			adcoc_pkg::ADDR_OUTMODE: rb_sel = rb_sync[4];
			adcoc_pkg::ADDR_DCO: rb_sel = rb_sync[5];
			default: rb_sel = 8'h00;
		endcase
	end

	// Frame shifter: instruction, then one data byte, MSB first
	always_comb begin
		next_f = f;
		next_w = w;
		next_f.sh = {f.sh[13:0], sdio_i};
		if (f.cnt != adcoc_pkg::FRAME_LAST + 5'h01) begin
			next_f.cnt = f.cnt + 5'h01;
		end
		if (f.cnt == adcoc_pkg::INSTR_LAST) begin
			next_f.rd = f.sh[adcoc_pkg::RW_BIT-1];
			next_f.addr = {f.sh[AW-2:0], sdio_i};
			next_f.rdb = {rb_sel[6:0], 1'b0};
			next_f.oe = f.sh[adcoc_pkg::RW_BIT-1];
		end else begin
			next_f.rdb = {f.rdb[6:0], 1'b0};
		end
		if (f.cnt == adcoc_pkg::FRAME_LAST) begin
			next_f.oe = 1'b0;
			if (!f.rd) begin
				next_w.tog = ~w.tog;
				next_w.addr = f.addr;
				next_w.data = {f.sh[6:0], sdio_i};
			end
		end
		if (!srst_b) begin
			next_w.tog = 1'b0;
		end
	end

	// First data bit must be ready right after the instruction edge
	logic sdio_q;
	always_ff @(posedge spi_sclk_i or posedge spi_cs_b_i) begin
		if (spi_cs_b_i) begin
			f <= '0;
			sdio_q <= 1'b0;
		end else begin
			f <= next_f;
			sdio_q <= (f.cnt == adcoc_pkg::INSTR_LAST) ? rb_sel[7] : f.rdb[7];
		end
	end

	// Write word holding register, stable until the next write
	always_ff @(posedge spi_sclk_i) begin
		w <= next_w;
	end
	assign sdio_o = sdio_q;
	assign sdio_oe_o = f.oe;

	// ********************************
	// Crossing into the sample clock domain
	// ********************************
	logic tog_sync;
	logic [AW+7:0] word_sync;
	logic [2:0] pin_sync;
	logic [1:0] strap_sync;

	adcoc_sync #(.W(1)) u_tog (
		.clk_i(ref_clk_i),
		.d_i(w.tog),
		.q_o(tog_sync)
	);
	adcoc_sync #(.W(AW + 8)) u_word (
		.clk_i(ref_clk_i),
		.d_i({w.addr, w.data}),
		.q_o(word_sync)
	);
	adcoc_sync #(.W(3)) u_pins (
		.clk_i(ref_clk_i),
		.d_i({power_down_pin_i, output_disable_i, clock_below_min_i}),
		.q_o(pin_sync)
	);
	adcoc_sync #(.W(2)) u_strap (
		.clk_i(ref_clk_i),
		.d_i({format_strap_pin_i, stabilizer_strap_pin_i}),
		.q_o(strap_sync)
	);

	// ********************************
	// Sample clock domain state
	// ********************************
	typedef struct packed {
		logic init;
		logic fmt_strap;
		logic dcs_strap;
		logic spi_mode;
		logic tog_q;
		logic tog_seen;
		logic [1:0] chan_sel;
		logic [1:0] pwr;
		logic dcs_en;
		logic [CH-1:0][1:0] fmt;
		logic [CH-1:0] dis;
		logic [CH-1:0] inv;
		logic [adcoc_pkg::RELOCK_W-1:0] relock;
		logic [NST-1:0][WW-1:0] pipe;
		logic [NST-1:0] pv;
		logic [CH-1:0][SW-1:0] dout;
		logic [CH-1:0] dor;
		logic [CH-1:0] data_clock_out;
	} adcoc_core_type;

	adcoc_core_type s;
	adcoc_core_type next_s;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [WW-1:0] buf_out;
	logic pd;
	logic standby;
	logic conv_on;
	logic dcs_eff;
	logic wr_ev;
	logic [AW-1:0] wa;
	logic [7:0] wd;
	logic ch_rb;
	// Word crosses one cycle before its toggle is acted on
	assign wr_ev = s.tog_q != s.tog_seen;
	assign wa = word_sync[AW+7:8];
	assign wd = word_sync[7:0];
	assign ch_rb = !s.chan_sel[0];
	// Power state from pin and serial setting
	assign pd = pin_sync[2] || (s.pwr == adcoc_pkg::PWR_DOWN); // [RQ4] [RQ6] [RQ18]
	assign standby = !pd && (s.pwr == adcoc_pkg::PWR_STANDBY); // [RQ7]
	assign conv_on = !pd && !standby;
	assign dcs_eff = s.spi_mode ? s.dcs_en : s.dcs_strap; // [RQ9]
	adcoc_buf2 #(.W(WW)) u_buf (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(s.pv[NST-1]),
		.in_ready_o(buf_in_ready),
		.in_data_i(s.pipe[NST-1]),
		.out_valid_o(buf_out_valid),
		.out_ready_i(out_ready_i),
		.out_data_o(buf_out)
	);

	// Register writes, pipeline, formatting and output latch
	always_comb begin
		logic [SW-1:0] raw;
		logic [1:0] fsel;
		raw = '0;
		fsel = '0;
		next_s = s;
		next_s.tog_q = tog_sync;
		next_s.tog_seen = s.tog_q;
		if (!s.init) begin
			next_s.init = 1'b1;
			next_s.fmt_strap = strap_sync[1]; // [RQ8]
			next_s.dcs_strap = strap_sync[0]; // [RQ9]
		end
		if (wr_ev) begin
			next_s.spi_mode = 1'b1;
			unique case (wa)
				adcoc_pkg::ADDR_CHAN: next_s.chan_sel = wd[1:0];
				adcoc_pkg::ADDR_POWER: next_s.pwr = wd[1:0]; // [RQ4] [RQ7]
				adcoc_pkg::ADDR_CLOCK: next_s.dcs_en = wd[adcoc_pkg::CLK_DCS_BIT];
				default: next_s.spi_mode = 1'b1;
			endcase
			for (int c = 0; c < CH; c++) begin
				if (s.chan_sel[c] && wa == adcoc_pkg::ADDR_OUTMODE) begin
					next_s.fmt[c] = wd[1:0]; // [RQ10]
					next_s.dis[c] = wd[adcoc_pkg::OM_DIS_BIT]; // [RQ12]
				end
				if (s.chan_sel[c] && wa == adcoc_pkg::ADDR_DCO) begin
					next_s.inv[c] = wd[adcoc_pkg::DCO_INV_BIT]; // [RQ15]
				end
			end
		end
		// Relock hold after any sample rate change
		if (clock_rate_change_i) begin
			next_s.relock = adcoc_pkg::RELOCK_CYC; // [RQ3]
		end else if (s.relock != '0) begin
			next_s.relock = s.relock - 1'b1;
		end
		// Shift only while the buffer accepts, so a stall loses no word already in the pipeline; samples arriving meanwhile are dropped
		if (buf_in_ready) begin
			next_s.pipe[0] = {overrange_i, sample_i};
			next_s.pv[0] = 1'b1;
			for (int k = 1; k < NST; k++) begin
				next_s.pipe[k] = s.pipe[k-1]; // [RQ13]
				next_s.pv[k] = s.pv[k-1];
			end
		end
		// Output latch loads after a rising edge, clock strobe loads on the same edge
		next_s.data_clock_out = '0;
		if (buf_out_valid && out_ready_i) begin
			for (int c = 0; c < CH; c++) begin
				raw = buf_out[c*SW +: SW];
				fsel = s.spi_mode ? s.fmt[c] : {1'b0, s.fmt_strap};
				unique case (fsel)
					adcoc_pkg::FMT_TWOS: next_s.dout[c] = {~raw[SW-1], raw[SW-2:0]}; // [RQ16]
					adcoc_pkg::FMT_GRAY: next_s.dout[c] = raw ^ (raw >> 1); // [RQ17]
					default: next_s.dout[c] = raw; // [RQ16]
				endcase
				next_s.dor[c] = buf_out[CH*SW + c]; // [RQ16]
			end
			next_s.data_clock_out = '1; // [RQ14]
		end
		if (!rst_b_i) begin
			next_s.init = 1'b0;
			next_s.fmt_strap = 1'b0;
			next_s.dcs_strap = adcoc_pkg::DCS_RST;
			next_s.spi_mode = 1'b0;
			next_s.tog_q = tog_sync;
			next_s.tog_seen = tog_sync;
			next_s.chan_sel = adcoc_pkg::CHAN_RST;
			next_s.pwr = adcoc_pkg::PWR_RUN;
			next_s.dcs_en = adcoc_pkg::DCS_RST;
			next_s.fmt = '0;
			next_s.dis = '0;
			next_s.inv = '0;
			next_s.relock = '0;
			next_s.pv = '0;
			next_s.dout = '0;
			next_s.dor = '0;
			next_s.data_clock_out = '0;
		end
	end

	// Core state register
	always_ff @(posedge ref_clk_i) begin
		s <= next_s;
	end

	// ********************************
	// Readback image and outputs
	// ********************************
	// Status bits may tear across the crossing; each is a slow level
	always_comb begin
		rb_bytes = '0;
		rb_bytes[0][adcoc_pkg::ST_PD_BIT] = pd;
		rb_bytes[0][adcoc_pkg::ST_SB_BIT] = standby;
		rb_bytes[0][adcoc_pkg::ST_DCS_BIT] = duty_stabilizer_o;
		rb_bytes[0][adcoc_pkg::ST_SPI_BIT] = s.spi_mode;
		rb_bytes[1][1:0] = s.chan_sel;
		rb_bytes[2][1:0] = s.pwr;
		rb_bytes[3][adcoc_pkg::CLK_DCS_BIT] = s.dcs_en;
		rb_bytes[4][1:0] = s.fmt[ch_rb];
		rb_bytes[4][adcoc_pkg::OM_DIS_BIT] = s.dis[ch_rb];
		rb_bytes[5][adcoc_pkg::DCO_INV_BIT] = s.inv[ch_rb];
	end
	// Pin, per-channel bit and power state all float the drivers
	for (genvar c = 0; c < CH; c++) begin : g_out
		assign data_oe_o[c] = conv_on && !pin_sync[1] && !s.dis[c]; // [RQ5] [RQ11] [RQ12]
		assign data_clock_out_oe_o[c] = data_oe_o[c]; // [RQ5] [RQ11] [RQ12]
		assign data_clock_out_o[c] = s.data_clock_out[c] ^ s.inv[c]; // [RQ15]
	end
	assign data_o = s.dout;
	assign overrange_o = s.dor;
	// Falling edge retimed only above the loop's lower rate and once relocked
	assign duty_stabilizer_o = dcs_eff && conv_on && !pin_sync[0] && (s.relock == '0); // [RQ1] [RQ2]
	assign reference_on_o = !pd; // [RQ7]
	assign converter_on_o = conv_on; // [RQ6]
	assign power_down_o = pd; // [RQ4] [RQ18]
endmodule : adcoc_top

// ===== adcoc_top_monitor.sv
// Checker of the power, drive-enable and stabilizer pins of the output control
module adcoc_top_chk #(
	parameter int CH = 2,
	parameter int SW = 10
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Pins and monitor inputs
	input wire logic power_down_pin_i,
	input wire logic output_disable_i,
	input wire logic clock_below_min_i,
	input wire logic clock_rate_change_i,
	input wire logic out_ready_i,
	// Output bus
	input wire logic [CH-1:0][SW-1:0] data_o,
	input wire logic [CH-1:0] data_oe_o,
	input wire logic [CH-1:0] data_clock_out_oe_o,
	// Analog control
	input wire logic duty_stabilizer_o,
	input wire logic reference_on_o,
	input wire logic converter_on_o,
	input wire logic power_down_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// Pin repeats cover the two-flop sync delay
	chk_pin_pd: assert property (power_down_pin_i [*4] |-> power_down_o)
		else $error("pin power-down not applied");
	chk_pd_float: assert property (
		power_down_o [*2] |-> !data_oe_o && !data_clock_out_oe_o)
		else $error("outputs driven while powered down");
	chk_pd_ref: assert property (power_down_o [*2] |-> !reference_on_o && !converter_on_o)
		else $error("analog still on in power-down");
	chk_stby_ref: assert property (converter_on_o |-> reference_on_o && !power_down_o)
		else $error("converter on without reference");
	chk_oe_pin: assert property (
		output_disable_i [*4] |-> !data_oe_o && !data_clock_out_oe_o)
		else $error("outputs driven while disable pin high");
	chk_oe_pair: assert property (data_oe_o == data_clock_out_oe_o)
		else $error("data and clock enables differ");
	chk_slow_clk: assert property (clock_below_min_i [*4] |-> !duty_stabilizer_o)
		else $error("stabilizer on at slow clock");
	// Hold checked at cycles 2 and 299 of the 500-cycle relock wait
	chk_relock_hold: assert property (
		clock_rate_change_i |-> ##2 !duty_stabilizer_o ##297 !duty_stabilizer_o)
		else $error("stabilizer trusted during relock");
	chk_stall_hold: assert property (!out_ready_i |=> $stable(data_o))
		else $error("word changed during stall");

	// Main scenarios
	cov_pd: cover property (power_down_o [*2]);
	cov_stby: cover property (reference_on_o && !converter_on_o);
	cov_stall: cover property (!out_ready_i [*3]);
	cov_relock: cover property (clock_rate_change_i);
endmodule : adcoc_top_chk

bind adcoc_top adcoc_top_chk #(.CH(CH), .SW(SW)) u_adcoc_top_chk (.ref_clk_i, .rst_b_i,
	.power_down_pin_i, .output_disable_i, .clock_below_min_i, .clock_rate_change_i,
	.out_ready_i, .data_o, .data_oe_o, .data_clock_out_oe_o, .duty_stabilizer_o,
	.reference_on_o, .converter_on_o, .power_down_o);

// ===== test_adc_output_control.sv
// Self-checking bench of the converter output control
module test_adc_output_control;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_i = 0, rst_b_i = 0, spi_sclk_i = 0, spi_cs_b_i = 1, host_sdio = 0;
	logic format_strap_pin_i = 0, stabilizer_strap_pin_i = 0, power_down_pin_i = 0;
	logic output_disable_i = 0, clock_below_min_i = 0, clock_rate_change_i = 0, stall = 0;
	logic [19:0] sample_i = 20'h0_0000, data_o;
	logic [1:0] overrange_i = 2'h0, overrange_o, data_oe_o, data_clock_out_o, data_clock_out_oe_o;
	logic sdio_o, sdio_oe_o, out_ready_i, duty_stabilizer_o, reference_on_o, converter_on_o;
	logic power_down_o, cv, chk_en = 0;
	logic [1:0] fm = 2'h0;
	logic [7:0] q;
	logic [21:0] rv, cap;
	logic [21:0] hist [0:65535];
	int n_fail = 0, cmp_count = 0, cyc = 0, seed = 17;
	// Device drives the shared data line only in its read phase
	wire sdio_w = sdio_oe_o ? sdio_o : host_sdio;

	adcoc_top u_adcoc_top (.ref_clk_i, .rst_b_i, .spi_sclk_i, .spi_cs_b_i, .sdio_i(sdio_w),
		.sdio_o, .sdio_oe_o, .format_strap_pin_i, .stabilizer_strap_pin_i, .power_down_pin_i,
		.output_disable_i, .clock_below_min_i, .clock_rate_change_i, .sample_i, .overrange_i,
		.out_ready_i, .data_o, .overrange_o, .data_oe_o, .data_clock_out_o, .data_clock_out_oe_o,
		.duty_stabilizer_o, .reference_on_o, .converter_on_o, .power_down_o);
	adcoc_cap_model u_adcoc_cap_model (.ref_clk_i, .stall_i(stall), .data_i(data_o),
		.ovr_i(overrange_o), .dco_i(data_clock_out_o[0]), .dco_oe_i(data_clock_out_oe_o[0]),
		.ready_o(out_ready_i), .cap_o(cap), .cap_vld_o(cv));

	// Sample clock
	always #5 ref_clk_i = ~ref_clk_i;

	// Expected coding of one channel word
	function automatic logic [9:0] f1(input logic [1:0] m, input logic [9:0] r);
		return m == 2'h1 ? {~r[9], r[8:0]} : m == 2'h2 ? r ^ (r >> 1) : r;
	endfunction : f1
	function automatic logic [21:0] xf(input logic [21:0] r);
		return {r[21:20], f1(fm, r[19:10]), f1(fm, r[9:0])};
	endfunction : xf

	task automatic cmp_w(input string n, input logic [21:0] e, input logic [21:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : cmp_w
	task automatic cmp_b(input string n, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask : cmp_b
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : wt
	// One frame, MSB first; read bits taken just before each rising edge
	task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] d);
		logic [23:0] w;
		w = {rd, 2'h0, a, d};
		spi_cs_b_i = 0;
		for (int i = 23; i >= 0; i--) begin
			host_sdio = w[i];
			#62.5;
			if (i < 8) q[i] = sdio_o;
			if (i < 8) cmp_b("sdio drive", rd, sdio_oe_o);
			spi_sclk_i = 1;
			#62.5;
			spi_sclk_i = 0;
		end
		#62.5 spi_cs_b_i = 1;
		wt(10);
	endtask : spi
	// Reset also needs link-clock edges to clear the serial side
	task automatic rst(input logic f, input logic s);
		rst_b_i <= 0;
		format_strap_pin_i <= f;
		stabilizer_strap_pin_i <= s;
		repeat (3) begin
			#62.5 spi_sclk_i = 1;
			#62.5 spi_sclk_i = 0;
		end
		wt(5);
		rst_b_i <= 1;
		wt(3);
	endtask : rst
	// Let words in flight drain, then check a stretch of traffic
	task automatic run(input logic [1:0] m);
		fm = m;
		wt(30);
		chk_en <= 1;
		wt(60);
		chk_en <= 0;
	endtask : run
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run

	// Random samples with full-scale and midscale corners
	always @(posedge ref_clk_i) begin
		rv = 22'($random(seed));
		case (cyc % 8)
			0: rv[19:0] = 20'h0_0000;
			1: rv[19:0] = 20'hF_FFFF;
			2: rv[19:0] = 20'h8_0200;
			default: ;
		endcase
		{overrange_i, sample_i} <= rv;
		hist[cyc[15:0]] <= rv;
		cyc <= cyc + 1;
		if (chk_en) cmp_b("capture valid", 1'b1, cv);
		if (chk_en && cv === 1'b1) cmp_w("word", xf(hist[cyc[15:0] - 16'd12]), cap);
	end

	initial begin
		rst(1'b1, 1'b0);
		cmp_b("strap duty", 1'b0, duty_stabilizer_o);
		run(2'h1);
		rst(1'b0, 1'b1);
		wt(5);
		cmp_b("strap duty", 1'b1, duty_stabilizer_o);
		run(2'h0);
		power_down_pin_i <= 1;
		wt(6);
		cmp_w("pd", 22'h0_0040, 22'({power_down_o, reference_on_o, converter_on_o, data_oe_o,
			data_clock_out_oe_o}));
		power_down_pin_i <= 0;
		wt(6);
		cmp_w("wake", 22'h0_003F, 22'({power_down_o, reference_on_o, converter_on_o, data_oe_o,
			data_clock_out_oe_o}));
		run(2'h0);
		output_disable_i <= 1;
		wt(6);
		cmp_w("oe pin", 22'h0_0000, 22'({data_oe_o, data_clock_out_oe_o}));
		output_disable_i <= 0;
		wt(6);
		cmp_w("oe pin", 22'h0_000F, 22'({data_oe_o, data_clock_out_oe_o}));
		// Every serial coding, read back then checked on the bus
		for (int m = 0; m < 3; m++) begin
			spi(1'b0, 13'h0014, 8'(m));
			spi(1'b1, 13'h0014, 8'h00);
			cmp_w("mode read", 22'(m), 22'(q));
			run(2'(m));
		end
		spi(1'b1, 13'h0123, 8'h00);
		cmp_w("unmapped", 22'h0_0000, 22'(q));
		spi(1'b0, 13'h0014, 8'h10);
		cmp_w("dis both", 22'h0_0000, 22'({data_oe_o, data_clock_out_oe_o}));
		spi(1'b0, 13'h0005, 8'h02);
		spi(1'b0, 13'h0014, 8'h00);
		cmp_w("dis a", 22'h0_000A, 22'({data_oe_o, data_clock_out_oe_o}));
		// Invert only the selected channel's data clock
		spi(1'b0, 13'h0016, 8'h80);
		cmp_w("dco inv", 22'h0_0001, 22'(data_clock_out_o));
		// Power register: down, standby, run
		spi(1'b0, 13'h0008, 8'h01);
		cmp_w("pwr", 22'h0_0004, 22'({power_down_o, reference_on_o, converter_on_o}));
		spi(1'b0, 13'h0008, 8'h02);
		cmp_w("pwr", 22'h0_0002, 22'({power_down_o, reference_on_o, converter_on_o}));
		spi(1'b1, 13'h0001, 8'h00);
		cmp_w("status", 22'h0_000A, 22'(q));
		spi(1'b0, 13'h0008, 8'h00);
		cmp_w("pwr", 22'h0_0003, 22'({power_down_o, reference_on_o, converter_on_o}));
		// Serial stabilizer enable off, then back on
		spi(1'b0, 13'h0009, 8'h00);
		cmp_b("duty reg", 1'b0, duty_stabilizer_o);
		spi(1'b0, 13'h0009, 8'h01);
		// Relock hold and slow clock
		cmp_b("duty", 1'b1, duty_stabilizer_o);
		clock_rate_change_i <= 1;
		wt(1);
		clock_rate_change_i <= 0;
		wt(5);
		cmp_b("relock", 1'b0, duty_stabilizer_o);
		wt(505);
		cmp_b("relocked", 1'b1, duty_stabilizer_o);
		clock_below_min_i <= 1;
		wt(6);
		cmp_b("slow", 1'b0, duty_stabilizer_o);
		clock_below_min_i <= 0;
		wt(6);
		cmp_b("fast", 1'b1, duty_stabilizer_o);
		// Receiver stalls long enough to fill the buffer
		stall <= 1;
		wt(8);
		cmp_b("stall dco", 1'b1, data_clock_out_o[1]);
		stall <= 0;
		wt(20);
		complete_run;
	end

	// Watchdog well beyond the expected run
	initial begin
		#400000;
		n_fail++;
		complete_run;
	end
endmodule : test_adc_output_control
